// ### hdl/ppgd_lfsr.sv
`timescale 1ns/10ps
`default_nettype none
`include "ppgd_map.svh"

module ppgd_lfsr
  import ppgd_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire ppgd_pat_t sel,
  input  wire logic      shift,
  input  wire logic      load_ext,
  input  wire logic      ext_bit,
  output logic           fb
);

  ppgd_lfsr_st_t st_ff;
  ppgd_lfsr_st_t nxt_st;

  // --------------------------------------------------------------------------
  // Feedback and lock-up detect per length
  // --------------------------------------------------------------------------
  function automatic logic pat_fb(input ppgd_pat_t s, input logic [19:0] t);
    unique case (s)
      PPGD_PAT_20: pat_fb = t[19] ^ t[2];
      PPGD_PAT_11: pat_fb = t[10] ^ t[8];
      default:     pat_fb = t[14] ^ t[13];
    endcase
  endfunction

  function automatic logic pat_zero(input ppgd_pat_t s, input logic [19:0] t);
    unique case (s)
      PPGD_PAT_20: pat_zero = (t[19:0] == 20'h00000);
      PPGD_PAT_11: pat_zero = (t[10:0] == 11'h000);
      default:     pat_zero = (t[14:0] == 15'h0000);
    endcase
  endfunction

  assign fb = pat_fb(sel, st_ff.taps);

  // Generator escapes the all-zero state; the detector follows received bits
  always_comb
  begin
    nxt_st = st_ff;
    if (shift)
    begin
      if (load_ext)
        nxt_st.taps = {st_ff.taps[18:0], ext_bit};
      else
        nxt_st.taps = {st_ff.taps[18:0], fb | pat_zero(sel, st_ff.taps)};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '{taps: `PPGD_RST_TAPS};
    else
      st_ff <= nxt_st;
  end

endmodule

`default_nettype wire

// ### hdl/ppgd_map.svh
`ifndef PPGD_MAP_SVH
`define PPGD_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PPGD_ADDR_CTRL      8'h71
`define PPGD_ADDR_STAT      8'h72
`define PPGD_ADDR_FLAG      8'h73

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PPGD_CTRL_SEL_LO    0
`define PPGD_CTRL_SEL_HI    1
`define PPGD_CTRL_GEN_FLIP  2
`define PPGD_CTRL_DET_FLIP  3
`define PPGD_STAT_SYNC_EN   0
`define PPGD_STAT_SYNC      1
`define PPGD_STAT_INJECT    2
`define PPGD_STAT_BER_EN    3
`define PPGD_FLAG_SYNC      0
`define PPGD_FLAG_BER       3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PPGD_RST_BYTE       8'h00
`define PPGD_RST_TAPS       20'h00000

// ----------------------------------------------------------------------------
// Detector thresholds: run and window in bit periods, loss in errors
// ----------------------------------------------------------------------------
`define PPGD_SYNC_RUN       6'h30
`define PPGD_WIN_LAST       6'h2F
`define PPGD_LOSS_ERRS      4'hA

`endif

// ### hdl/ppgd_pkg.sv
package ppgd_pkg;

  // --------------------------------------------------------------------------
  // Pattern codes and detector states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PPGD_PAT_15   = 2'b00,
    PPGD_PAT_20   = 2'b01,
    PPGD_PAT_11   = 2'b10,
    PPGD_PAT_RSVD = 2'b11
  } ppgd_pat_t;

  typedef enum logic {
    PPGD_HUNT   = 1'b0,
    PPGD_LOCKED = 1'b1
  } ppgd_sync_t;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic       data;
  } ppgd_bit_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ppgd_bus_t;

  typedef struct packed {
    logic [19:0] taps;
  } ppgd_lfsr_st_t;

endpackage

// ### hdl/ppgd_top.sv
// Contract
// - The two-bit pattern select picks 2^15-1 (00), 2^20-1 (01) or 2^11-1 (10) for generator and detector.
// - A pending bit-error flag drives the interrupt only while its enable is 1.
// - Setting the inject bit flips exactly one generated bit, after which hardware clears the bit.
// - Ten or more errors inside a fixed 48-bit window take the detector out of sync.
// - At least 48 consecutive error-free bits bring the detector into sync.
// - The sync state reads as a read-only status bit, 1 in sync and 0 out of sync.
// - A pending sync-change flag drives the interrupt only while its enable is 1.
// - Any mismatched bit while in sync sets the sticky bit-error flag, cleared by writing 1.
// - Every change of the sync state sets the sticky sync-change flag, cleared by writing 1.
// - With the generator flip control at 1 the generated pattern is complemented.
// - With the detector flip control at 1 received data is complemented before detection.
`timescale 1ns/10ps
`default_nettype none
`include "ppgd_map.svh"

module ppgd_top
  import ppgd_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire ppgd_bus_t bus,
  output logic [7:0]     rd_data,
  input  wire logic      tx_en,
  output logic           tx_bit,
  input  wire ppgd_bit_t rx,
  output logic           irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    ppgd_pat_t  pattern_select;
    logic       generator_output_flip;
    logic       detector_input_flip;
    logic       bit_error_irq_enable;
    logic       one_error_inject;
    logic       sync_change_irq_enable;
    ppgd_sync_t sync_state;
    logic       bit_error_flag;
    logic       sync_change_flag;
    logic [5:0] run_cnt;
    logic [5:0] win_cnt;
    logic [3:0] err_cnt;
    logic       tx_bit;
    logic [7:0] rd_data;
    logic       irq;
  } ppgd_st_t;

  ppgd_st_t st_ff;
  ppgd_st_t nxt_st;

  logic gen_fb;
  logic det_fb;
  logic det_in;
  logic det_err;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_flag;
  logic ber_evt;
  logic sync_evt;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] read_word(input logic [7:0] a, input ppgd_st_t s);
    logic [7:0] w;
    w = `PPGD_RST_BYTE;
    unique case (a)
      `PPGD_ADDR_CTRL:
      begin
        w[`PPGD_CTRL_SEL_HI:`PPGD_CTRL_SEL_LO] = s.pattern_select;
        w[`PPGD_CTRL_GEN_FLIP]                 = s.generator_output_flip;
        w[`PPGD_CTRL_DET_FLIP]                 = s.detector_input_flip;
      end
      `PPGD_ADDR_STAT:
      begin
        w[`PPGD_STAT_SYNC_EN] = s.sync_change_irq_enable;
        w[`PPGD_STAT_SYNC]    = (s.sync_state == PPGD_LOCKED);
        w[`PPGD_STAT_INJECT]  = s.one_error_inject;
        w[`PPGD_STAT_BER_EN]  = s.bit_error_irq_enable;
      end
      `PPGD_ADDR_FLAG:
      begin
        w[`PPGD_FLAG_SYNC] = s.sync_change_flag;
        w[`PPGD_FLAG_BER]  = s.bit_error_flag;
      end
      default:
        w = `PPGD_RST_BYTE;
    endcase
    return w;
  endfunction

  function automatic logic irq_level(input ppgd_st_t s);
    return (s.bit_error_flag & s.bit_error_irq_enable) |
           (s.sync_change_flag & s.sync_change_irq_enable);
  endfunction

  // --------------------------------------------------------------------------
  // Pattern engines
  // --------------------------------------------------------------------------
  ppgd_lfsr u_gen (
    .clk      (clk),
    .rst_n    (rst_n),
    .sel      (st_ff.pattern_select),
    .shift    (tx_en),
    .load_ext (1'b0),
    .ext_bit  (1'b0),
    .fb       (gen_fb)
  );

  ppgd_lfsr u_det (
    .clk      (clk),
    .rst_n    (rst_n),
    .sel      (st_ff.pattern_select),
    .shift    (rx.en),
    .load_ext (1'b1),
    .ext_bit  (det_in),
    .fb       (det_fb)
  );

  assign det_in  = rx.data ^ st_ff.detector_input_flip;
  assign det_err = det_in ^ det_fb;

  assign wr_ctrl = bus.wr && (bus.addr == `PPGD_ADDR_CTRL);
  assign wr_stat = bus.wr && (bus.addr == `PPGD_ADDR_STAT);
  assign wr_flag = bus.wr && (bus.addr == `PPGD_ADDR_FLAG);

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_st   = st_ff;
    ber_evt  = 1'b0;
    sync_evt = 1'b0;

    // Transmit: inject flips only the output, so the sequence stays intact
    if (tx_en)
    begin
      nxt_st.tx_bit           = gen_fb ^ st_ff.generator_output_flip
                                ^ st_ff.one_error_inject;
      nxt_st.one_error_inject = 1'b0;
    end

    // Detector sync machine
    if (rx.en)
    begin
      unique case (st_ff.sync_state)
        PPGD_HUNT:
        begin
          if (det_err)
            nxt_st.run_cnt = 6'h00;
          else if (st_ff.run_cnt + 6'h01 == `PPGD_SYNC_RUN)
          begin
            nxt_st.sync_state = PPGD_LOCKED;
            nxt_st.run_cnt    = 6'h00;
            nxt_st.win_cnt    = 6'h00;
            nxt_st.err_cnt    = 4'h0;
          end
          else
            nxt_st.run_cnt = st_ff.run_cnt + 6'h01;
        end
        PPGD_LOCKED:
        begin
          nxt_st.err_cnt = st_ff.err_cnt + {3'h0, det_err};
          nxt_st.win_cnt = st_ff.win_cnt + 6'h01;
          if (det_err)
          begin
            ber_evt               = 1'b1;
            nxt_st.bit_error_flag = 1'b1;
          end
          if (nxt_st.err_cnt >= `PPGD_LOSS_ERRS)
          begin
            nxt_st.sync_state = PPGD_HUNT;
            nxt_st.run_cnt    = 6'h00;
            nxt_st.win_cnt    = 6'h00;
            nxt_st.err_cnt    = 4'h0;
          end
          else if (st_ff.win_cnt == `PPGD_WIN_LAST)
          begin
            nxt_st.win_cnt = 6'h00;
            nxt_st.err_cnt = 4'h0;
          end
        end
      endcase
    end

    if (nxt_st.sync_state != st_ff.sync_state)
    begin
      sync_evt                = 1'b1;
      nxt_st.sync_change_flag = 1'b1;
    end

    // Software writes; a write to the inject bit lands after the hardware clear
    if (wr_ctrl)
    begin
      nxt_st.pattern_select        = ppgd_pat_t'(bus.wdata[`PPGD_CTRL_SEL_HI:`PPGD_CTRL_SEL_LO]);
      nxt_st.generator_output_flip = bus.wdata[`PPGD_CTRL_GEN_FLIP];
      nxt_st.detector_input_flip   = bus.wdata[`PPGD_CTRL_DET_FLIP];
    end
    if (wr_stat)
    begin
      nxt_st.sync_change_irq_enable = bus.wdata[`PPGD_STAT_SYNC_EN];
      nxt_st.one_error_inject       = bus.wdata[`PPGD_STAT_INJECT];
      nxt_st.bit_error_irq_enable   = bus.wdata[`PPGD_STAT_BER_EN];
    end
    // Clear only what was pending before this cycle, so a new event wins
    if (wr_flag)
    begin
      nxt_st.bit_error_flag   = (st_ff.bit_error_flag & ~bus.wdata[`PPGD_FLAG_BER]) | ber_evt;
      nxt_st.sync_change_flag = (st_ff.sync_change_flag & ~bus.wdata[`PPGD_FLAG_SYNC]) | sync_evt;
    end

    nxt_st.rd_data = bus.rd ? read_word(bus.addr, st_ff) : `PPGD_RST_BYTE;
    nxt_st.irq     = irq_level(nxt_st);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff                        <= '0;
      st_ff.pattern_select         <= PPGD_PAT_15;
      st_ff.sync_state             <= PPGD_HUNT;
    end
    else
      st_ff <= nxt_st;
  end

  assign rd_data = st_ff.rd_data;
  assign tx_bit  = st_ff.tx_bit;
  assign irq     = st_ff.irq;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_inject_armed;
    st_ff.one_error_inject && !wr_stat;
  endsequence

  sequence s_tx_taken;
    tx_en;
  endsequence

  inject_self_clear_a: assert property (s_inject_armed ##0 s_tx_taken |=>
      !st_ff.one_error_inject && (tx_bit == !($past(gen_fb) ^ $past(st_ff.generator_output_flip))))
    else $error("inject bit not consumed on one transmitted bit");

  tx_flip_a: assert property (tx_en && !st_ff.one_error_inject |=>
      tx_bit == ($past(gen_fb) ^ $past(st_ff.generator_output_flip)))
    else $error("transmit bit does not follow pattern and flip");

  irq_ber_gate_a: assert property (st_ff.bit_error_flag && !st_ff.bit_error_irq_enable
      && !(st_ff.sync_change_flag && st_ff.sync_change_irq_enable) |-> !irq)
    else $error("disabled bit-error flag drives interrupt");

  irq_sync_gate_a: assert property (st_ff.sync_change_flag && st_ff.sync_change_irq_enable
      |-> irq)
    else $error("enabled sync-change flag not on interrupt");

  irq_hold_a: assert property (irq && !wr_flag && !wr_stat |=> irq)
    else $error("interrupt dropped without a clear");

  sync_gain_a: assert property (st_ff.sync_state == PPGD_HUNT && rx.en && !det_err
      && st_ff.run_cnt == 6'h2F |=> st_ff.sync_state == PPGD_LOCKED)
    else $error("sync not gained after 48 clean bits");

  sync_loss_a: assert property ($fell(st_ff.sync_state == PPGD_LOCKED) |->
      $past(st_ff.err_cnt) == 4'h9 && $past(det_err) && $past(rx.en))
    else $error("sync lost without ten errors in window");

  ber_flag_set_a: assert property (st_ff.sync_state == PPGD_LOCKED && rx.en && det_err
      |=> st_ff.bit_error_flag ##1 (st_ff.bit_error_flag || $past(wr_flag)))
    else $error("bit-error flag not set or not sticky");

  ber_set_wins_a: assert property (ber_evt && wr_flag |=> st_ff.bit_error_flag)
    else $error("bit-error clear beat a new error");

  sync_flag_set_a: assert property ($changed(st_ff.sync_state) |-> st_ff.sync_change_flag)
    else $error("sync change did not raise flag");

  status_read_a: assert property (bus.rd && bus.addr == `PPGD_ADDR_STAT |=>
      rd_data[`PPGD_STAT_SYNC] == ($past(st_ff.sync_state) == PPGD_LOCKED))
    else $error("status read does not show sync state");

endmodule

`default_nettype wire

// ### verification/ppgd_framer_model.sv
`timescale 1ns/10ps
`default_nettype none

module ppgd_framer_model
  import ppgd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic corrupt,
  input  wire logic tx_bit,
  output logic      tx_en,
  output ppgd_bit_t rx,
  output logic      hit
);
  // --------------------------------------------------------------------------
  // Loopback framer
  // --------------------------------------------------------------------------
  logic taken_ff;

  // Idle data toggles so a stale bit is never mistaken for a valid one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_en    <= 1'b0;
      taken_ff <= 1'b0;
      rx       <= '0;
      hit      <= 1'b0;
    end
    else
    begin
      tx_en    <= run & ~tx_en;
      taken_ff <= tx_en;
      rx.en    <= taken_ff;
      rx.data  <= taken_ff ? tx_bit ^ corrupt : ~rx.data;
      hit      <= taken_ff & corrupt;
    end
  end
endmodule

`default_nettype wire

// ### verification/prbs_pattern_gen_detect_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ppgd_map.svh"

module prbs_pattern_gen_detect_tb
  import ppgd_pkg::*;
;
  logic       clk;
  logic       rst_n;
  ppgd_bus_t  bus;
  logic [7:0] rd_data;
  logic       tx_en;
  logic       tx_bit;
  ppgd_bit_t  rx;
  logic       irq;
  logic       run;
  logic       corrupt;
  logic       hit;
  int         errors;
  int         samples_checked;
  int         cyc;
  int         nhit;
  int         nclean;
  int         b_used;
  logic       got_bits [0:99];
  logic       ref_bits [0:99];

  ppgd_top i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
                  .tx_en(tx_en), .tx_bit(tx_bit), .rx(rx), .irq(irq));

  ppgd_framer_model i_far (.clk(clk), .rst_n(rst_n), .run(run), .corrupt(corrupt),
                           .tx_bit(tx_bit), .tx_en(tx_en), .rx(rx), .hit(hit));

  // --------------------------------------------------------------------------
  // Clock, timeout, bit counters
  // --------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  always @(posedge clk)
  begin
    if (rx.en === 1'b1 && hit === 1'b1)
      nhit++;
    else if (rx.en === 1'b1)
      nclean++;
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    chk(rd_data, exp);
  endtask

  task automatic irq_chk(input logic lvl);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, {7'h00, lvl});
  endtask

  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 300 && irq !== lvl; i++)
      @(negedge clk);
    chk({7'h00, irq}, {7'h00, lvl});
  endtask

  task automatic do_reset(input logic [7:0] ctrl);
    @(posedge clk);
    run   <= 1'b0;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wr(`PPGD_ADDR_CTRL, ctrl);
  endtask

  task automatic pass_bits(input int n);
    repeat (n) @(posedge clk iff rx.en);
  endtask

  task automatic rec(input int n);
    run <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk iff rx.en);
      got_bits[i] = rx.data;
    end
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_regs();
    rd_chk(`PPGD_ADDR_CTRL, 8'h00);
    rd_chk(`PPGD_ADDR_STAT, 8'h00);
    rd_chk(`PPGD_ADDR_FLAG, 8'h00);
    wr(`PPGD_ADDR_CTRL, 8'hFF);
    wr(`PPGD_ADDR_STAT, 8'hFF);
    wr(8'h74, 8'hFF);
    rd_chk(`PPGD_ADDR_CTRL, 8'h0F);
    rd_chk(`PPGD_ADDR_STAT, 8'h0D);
    rd_chk(8'h74, 8'h00);
  endtask

  // Either tap ordering of each trinomial is accepted; code 11 runs as the 15-bit one
  task automatic t_patterns();
    int a [4] = '{15, 20, 11, 15};
    int b [4] = '{14, 3, 9, 14};
    int bad1;
    int bad2;
    for (int c = 0; c < 4; c++)
    begin
      do_reset({6'h00, c[1:0]});
      rec(100);
      bad1 = 0;
      bad2 = 0;
      for (int n = 45; n < 100; n++)
      begin
        bad1 += (got_bits[n] !== (got_bits[n-a[c]] ^ got_bits[n-b[c]]));
        bad2 += (got_bits[n] !== (got_bits[n-a[c]] ^ got_bits[n-a[c]+b[c]]));
      end
      chk({7'h00, bad1 != 0 && bad2 != 0}, 8'h00);
      if (c == 2)
        b_used = (bad1 == 0) ? b[c] : a[c] - b[c];
      pass_bits(60);
      rd_chk(`PPGD_ADDR_STAT, 8'h02);
      rd_chk(`PPGD_ADDR_FLAG, 8'h01);
    end
  endtask

  task automatic t_flip();
    do_reset(8'h02);
    rec(30);
    ref_bits = got_bits;
    do_reset(8'h06);
    rec(30);
    for (int n = 0; n < 30; n++)
      chk({7'h00, got_bits[n]}, {7'h00, ~ref_bits[n]});
    pass_bits(100);
    rd_chk(`PPGD_ADDR_STAT, 8'h00);
    wr(`PPGD_ADDR_CTRL, 8'h0E);
    pass_bits(100);
    rd_chk(`PPGD_ADDR_STAT, 8'h02);
  endtask

  task automatic t_inject();
    int diff;
    do_reset(8'h02);
    wr(`PPGD_ADDR_STAT, 8'h04);
    rec(30);
    diff = 0;
    for (int n = 0; n < 30; n++)
      diff += (got_bits[n] !== ref_bits[n]);
    chk(diff[7:0], 8'h01);
    rd_chk(`PPGD_ADDR_STAT, 8'h00);
    pass_bits(100);
    rd_chk(`PPGD_ADDR_FLAG, 8'h01);
    irq_chk(1'b0);
    wr(`PPGD_ADDR_STAT, 8'h04);
    pass_bits(30);
    rd_chk(`PPGD_ADDR_FLAG, 8'h09);
    rd_chk(`PPGD_ADDR_STAT, 8'h02);
    irq_chk(1'b0);
    wr(`PPGD_ADDR_STAT, 8'h08);
    irq_chk(1'b1);
    wr(`PPGD_ADDR_FLAG, 8'h08);
    rd_chk(`PPGD_ADDR_FLAG, 8'h01);
    irq_chk(1'b0);
    wr(`PPGD_ADDR_STAT, 8'h01);
    irq_chk(1'b1);
    wr(`PPGD_ADDR_FLAG, 8'h01);
    irq_chk(1'b0);
  endtask

  // A corrupted run looks clean while only the shorter tap is corrupted
  task automatic t_loss();
    int h0;
    int c0;
    int exp_loss;
    do_reset(8'h02);
    wr(`PPGD_ADDR_STAT, 8'h01);
    run <= 1'b1;
    wait_irq(1'b1);
    @(posedge clk);
    corrupt <= 1'b1;
    h0 = nhit;
    wr(`PPGD_ADDR_FLAG, 8'h01);
    wait_irq(1'b0);
    wait_irq(1'b1);
    exp_loss = (b_used >= 10) ? 10 : 21 - b_used;
    chk(8'(nhit - h0), 8'(exp_loss));
    rd_chk(`PPGD_ADDR_FLAG, 8'h09);
    rd_chk(`PPGD_ADDR_STAT, 8'h01);
    @(posedge clk);
    corrupt <= 1'b0;
    c0 = nclean;
    wr(`PPGD_ADDR_FLAG, 8'h09);
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk(8'(nclean - c0), 8'h3B);
  endtask

  initial
  begin
    bus     = '0;
    run     = 1'b0;
    corrupt = 1'b0;
    rst_n   = 1'b0;
    do_reset(8'h00);
    t_regs();
    t_patterns();
    t_flip();
    t_inject();
    t_loss();
    tally_and_finish();
  end
endmodule

`default_nettype wire
